// ### csfb_pkg.sv
package csfb_pkg;
  // register indices on the plain port (word addressed)
  localparam logic [3:0] CSFB_ADDR_DIAG   = 4'h0;
  localparam logic [3:0] CSFB_ADDR_REQ    = 4'h1;
  localparam logic [3:0] CSFB_ADDR_STATE  = 4'h2;
  localparam logic [3:0] CSFB_ADDR_LEDSEL = 4'h3;
  localparam logic [3:0] CSFB_ADDR_HEADIO = 4'h4;
  localparam logic [3:0] CSFB_ADDR_NET    = 4'h5;
  localparam logic [3:0] CSFB_ADDR_CLK0   = 4'h8;
  // diag register bit positions
  localparam int CSFB_B_DIAG   = 0;
  localparam int CSFB_B_SELF   = 1;
  localparam int CSFB_B_COMMON = 2;
  localparam int CSFB_B_INDIV  = 3;
  localparam int CSFB_B_BATL   = 4;
  localparam int CSFB_B_BATV   = 5;
  localparam int CSFB_B_DIP    = 6;
  localparam int CSFB_B_OPER   = 7;
  localparam int CSFB_B_FUSE   = 8;
  localparam int CSFB_B_IOVER  = 9;
  localparam int CSFB_B_ANN    = 10;
  localparam int CSFB_B_CHK    = 11;
  localparam int CSFB_B_FNET   = 12;
  localparam int CSFB_B_CLKERR = 13;
  localparam int CSFB_B_IOOK   = 14;
  // request register bit positions
  localparam int CSFB_B_ERST   = 0;
  localparam int CSFB_B_LEDOFF = 1;
  localparam int CSFB_B_PEN    = 2;
  localparam int CSFB_B_CSET   = 3;
  localparam int CSFB_B_CRD    = 4;
  localparam int CSFB_B_IOCHG  = 5;
  localparam int CSFB_B_STEP0  = 8;
  localparam logic [15:0] CSFB_RST_VAL = 16'h0000;
  // power dip windows
  localparam int CSFB_DIP_AC_NS  = 20000000;
  localparam int CSFB_DIP_DC_NS  = 1000000;
  localparam int CSFB_CLK_NS     = 25;
  localparam int CSFB_DIP_AC_CYC = CSFB_DIP_AC_NS / CSFB_CLK_NS;
  localparam int CSFB_DIP_DC_CYC = CSFB_DIP_DC_NS / CSFB_CLK_NS;

  typedef enum logic [1:0] {
    CSFB_RUN  = 2'b00,
    CSFB_STOP = 2'b01,
    CSFB_PAUSE = 2'b10,
    CSFB_STEP = 2'b11
  } csfb_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } csfb_bus_t;

  typedef struct packed {
    logic self_err;
    logic ann_err;
    logic chk_err;
    logic common_avail;
    logic indiv_avail;
    logic oper_err;
    logic fuse_err;
    logic iover_err;
    logic fnet_err;
  } csfb_err_t;
endpackage : csfb_pkg

// ### csfb_flag_bank.sv
`timescale 1ns/1ps
// Behaviour
// - diag flag sets on any error incl. annunciator/check, stays set
// - self-diag flag sets on errors except annunciator/check, stays set
// - common/individual info flags follow detail availability while diag flag set
// - rising edge of error reset request performs error reset
// - latched battery-low sets on low battery, stays, drives alarm LED
// - live battery-low follows battery state
// - power-dip sets on short supply loss (20ms AC, 1ms DC), cleared only by power-on
// - operation error flag sets on operation error and stays
// - blown fuse flag sets on any blown fuse and stays
// - io verify flag sets on configuration mismatch and stays
// - annunciator flag asserts while any annunciator bit set at execution
// - check detect flag sets on check error and stays
// - step monitor start flags run timers, clearing resets, only with chart program
// - rising led-off command blanks LEDs selected in select word
// - stop, pause, single-step state flags track operating state
// - pause entered on pause contact only if pause enable set
// - clock set rising edge writes valid clock words at the end of the scan following the request (second scan end)
// - clock data error reflects validity of words on set request
// - while clock read set, time copied into clock words as BCD
// - io change flag with head io word; ok flag raised at scan end
// - four net standby flags at init, read/write refresh inhibits per net
// - field network error flag sets on any error and stays
module csfb_flag_bank
  import csfb_pkg::*;
#(
  parameter int STEP_N    = 10,
  parameter int NET_N     = 4,
  parameter int DIP_AC_CYC = CSFB_DIP_AC_CYC,
  parameter int DIP_DC_CYC = CSFB_DIP_DC_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire csfb_bus_t         i_bus,
  output logic [15:0]            o_rdata,
  input  wire csfb_err_t         i_err,
  input  wire logic              i_exec_strobe,
  input  wire logic              i_scan_end,
  input  wire logic              i_sfc_present,
  input  wire logic              i_batt_low_pin,
  input  wire logic              i_supply_ok_pin,
  input  wire logic              i_supply_is_dc,
  input  wire logic              i_stop_req,
  input  wire logic              i_step_req,
  input  wire logic              i_pause_contact,
  input  wire logic              i_io_change_allowed,
  input  wire logic [NET_N-1:0]  i_net_standby_cfg,
  input  wire logic [63:0]       i_rtc_time_bcd,
  output logic                   o_error_reset_pulse,
  output logic                   o_batt_alarm_led,
  output logic [15:0]            o_led_blank,
  output logic                   o_rtc_write,
  output logic [63:0]            o_rtc_wdata,
  output logic [STEP_N-1:0]      o_step_timer_run,
  output logic [NET_N-1:0]       o_net_read_inhibit,
  output logic [NET_N-1:0]       o_net_write_inhibit,
  output csfb_state_t            o_state
);

  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [2:0] batt_sync_q;
  logic [2:0] sup_sync_q;
  logic       batt_q;
  logic       sup_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      batt_sync_q <= 3'h0;
      sup_sync_q  <= 3'h7;
      batt_q      <= 1'b0;
      sup_q       <= 1'b1;
    end else begin
      batt_sync_q <= {batt_sync_q[1:0], i_batt_low_pin};
      sup_sync_q  <= {sup_sync_q[1:0], i_supply_ok_pin};
      if (batt_sync_q[1] == batt_sync_q[2]) begin
        batt_q <= batt_sync_q[2];
      end
      if (sup_sync_q[1] == sup_sync_q[2]) begin
        sup_q <= sup_sync_q[2];
      end
    end
  end

  // bus decode
  wire wr_diag   = i_bus.wr && (i_bus.addr == CSFB_ADDR_DIAG);
  wire wr_req    = i_bus.wr && (i_bus.addr == CSFB_ADDR_REQ);
  wire wr_ledsel = i_bus.wr && (i_bus.addr == CSFB_ADDR_LEDSEL);
  wire wr_headio = i_bus.wr && (i_bus.addr == CSFB_ADDR_HEADIO);
  wire wr_net    = i_bus.wr && (i_bus.addr == CSFB_ADDR_NET);
  wire wr_clk    = i_bus.wr && (i_bus.addr[3:2] == CSFB_ADDR_CLK0[3:2]);

  logic [15:0]       req_q;
  logic [15:0]       req_prev_q;
  logic [15:0]       ledsel_q;
  logic [15:0]       headio_q;
  logic [15:0]       clk_words_q [4];
  logic [NET_N-1:0]  rinh_q;
  logic [NET_N-1:0]  winh_q;
  logic [NET_N-1:0]  standby_q;
  logic              init_done_q;
  logic [14:0]       diag_q;
  logic              cset_pend_q;
  logic              cset_arm_q;

  wire erst_rise   = req_q[CSFB_B_ERST] & ~req_prev_q[CSFB_B_ERST];
  wire ledoff_rise = req_q[CSFB_B_LEDOFF] & ~req_prev_q[CSFB_B_LEDOFF];
  wire cset_rise   = req_q[CSFB_B_CSET] & ~req_prev_q[CSFB_B_CSET];

  // only bits that name a request flag take a write; spare bits stay zero
  wire [15:0] req_wmask = (16'h1 << CSFB_B_ERST) | (16'h1 << CSFB_B_LEDOFF) | (16'h1 << CSFB_B_PEN)
                        | (16'h1 << CSFB_B_CSET) | (16'h1 << CSFB_B_CRD) | (16'h1 << CSFB_B_IOCHG)
                        | ~((16'h1 << CSFB_B_STEP0) - 16'h1);

  // clock data validity: every nibble must be a decimal digit
  wire [63:0] clk_flat = {clk_words_q[3], clk_words_q[2], clk_words_q[1], clk_words_q[0]};
  logic [15:0] nib_bad;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_nib
      assign nib_bad[g] = (clk_flat[g*4 +: 4] > 4'h9);
    end
  endgenerate
  wire clk_data_bad = |nib_bad;

  // power dip: supply lost and back within the window for the fitted supply
  logic [31:0] dip_cnt_q;
  wire [31:0] dip_lim = i_supply_is_dc ? 32'(DIP_DC_CYC) : 32'(DIP_AC_CYC);
  wire dip_event = sup_q && (dip_cnt_q != 32'h0) && (dip_cnt_q <= dip_lim);
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dip_cnt_q <= 32'h0;
    end else if (!sup_q) begin
      // saturate so a long outage can never wrap back into the dip window
      dip_cnt_q <= (dip_cnt_q == 32'hFFFFFFFF) ? dip_cnt_q : dip_cnt_q + 32'h1;
    end else begin
      dip_cnt_q <= 32'h0;
    end
  end

  // sticky flags: a new event wins over the error reset in the same cycle
  // error reset spares the latched battery and power-dip flags; only power-on clears those
  wire [14:0] erst_keep = (15'h1 << CSFB_B_BATL) | (15'h1 << CSFB_B_DIP);
  wire        set_diag  = i_err.self_err | i_err.ann_err | i_err.chk_err | i_err.oper_err
                        | i_err.fuse_err | i_err.iover_err | i_err.fnet_err;
  wire        set_self  = i_err.self_err | i_err.oper_err | i_err.fuse_err | i_err.iover_err
                        | i_err.fnet_err;
  wire        set_oper  = i_err.oper_err;
  wire        set_fuse  = i_err.fuse_err;
  wire        set_iover = i_err.iover_err;
  wire        set_chk   = i_err.chk_err;
  wire        set_fnet  = i_err.fnet_err;
  wire        iook_now  = req_q[CSFB_B_IOCHG] & i_io_change_allowed;
  wire [14:0] diag_base = erst_rise ? (diag_q & erst_keep) : diag_q;
  logic [14:0] diag_d;
  always_comb begin
    diag_d = diag_base;
    if (set_diag) diag_d[CSFB_B_DIAG] = 1'b1;
    if (set_self) diag_d[CSFB_B_SELF] = 1'b1;
    diag_d[CSFB_B_COMMON] = diag_d[CSFB_B_DIAG] & i_err.common_avail;
    diag_d[CSFB_B_INDIV]  = diag_d[CSFB_B_DIAG] & i_err.indiv_avail;
    if (batt_q) diag_d[CSFB_B_BATL] = 1'b1;
    diag_d[CSFB_B_BATV] = batt_q;
    if (dip_event) diag_d[CSFB_B_DIP] = 1'b1;
    if (set_oper) diag_d[CSFB_B_OPER] = 1'b1;
    if (set_fuse) diag_d[CSFB_B_FUSE] = 1'b1;
    if (set_iover) diag_d[CSFB_B_IOVER] = 1'b1;
    if (i_exec_strobe) diag_d[CSFB_B_ANN] = i_err.ann_err;
    if (set_chk) diag_d[CSFB_B_CHK] = 1'b1;
    if (set_fnet) diag_d[CSFB_B_FNET] = 1'b1;
    if (cset_rise) diag_d[CSFB_B_CLKERR] = clk_data_bad;
    if (i_scan_end) diag_d[CSFB_B_IOOK] = iook_now;
    if (!req_q[CSFB_B_IOCHG]) diag_d[CSFB_B_IOOK] = 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      diag_q <= 15'h0;
    end else begin
      diag_q <= diag_d;
    end
  end

  // user-writable request, selection and network registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      req_q      <= CSFB_RST_VAL;
      req_prev_q <= CSFB_RST_VAL;
      ledsel_q   <= CSFB_RST_VAL;
      headio_q   <= CSFB_RST_VAL;
      rinh_q     <= '0;
      winh_q     <= '0;
    end else begin
      req_prev_q <= req_q;
      if (wr_req) req_q <= i_bus.wdata & req_wmask;
      if (wr_ledsel) ledsel_q <= i_bus.wdata;
      if (wr_headio) headio_q <= i_bus.wdata;
      if (wr_net) begin
        rinh_q <= i_bus.wdata[NET_N-1:0];
        winh_q <= i_bus.wdata[2*NET_N-1:NET_N];
      end
    end
  end

  // standby flags are captured once after reset release, at initial processing
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      standby_q   <= '0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      standby_q   <= i_net_standby_cfg;
      init_done_q <= 1'b1;
    end
  end

  // clock words: user writes; read request overwrites with live BCD time
  for (g = 0; g < 4; g++) begin : g_clk
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        clk_words_q[g] <= CSFB_RST_VAL;
      end else if (req_q[CSFB_B_CRD]) begin
        clk_words_q[g] <= i_rtc_time_bcd[g*16 +: 16];
      end else if (wr_clk && (i_bus.addr[1:0] == 2'(g))) begin
        clk_words_q[g] <= i_bus.wdata;
      end
    end
  end

  // clock set waits for the end of the scan following the request
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cset_pend_q <= 1'b0;
      cset_arm_q  <= 1'b0;
      o_rtc_write <= 1'b0;
      o_rtc_wdata <= 64'h0;
    end else begin
      o_rtc_write <= 1'b0;
      if (cset_rise && !clk_data_bad) begin
        cset_pend_q <= 1'b1;
        cset_arm_q  <= 1'b0;
      end else if (cset_pend_q && i_scan_end) begin
        // first scan end closes the current scan, the second ends the next one
        if (cset_arm_q) begin
          cset_pend_q <= 1'b0;
          o_rtc_write <= 1'b1;
          o_rtc_wdata <= clk_flat;
        end else begin
          cset_arm_q <= 1'b1;
        end
      end
    end
  end

  // operating state
  csfb_state_t state_q;
  csfb_state_t state_d;
  csfb_state_t free_next;
  // outside pause the request levels decide: stop first, then step, then an enabled pause
  always_comb begin
    if (i_stop_req) free_next = CSFB_STOP;
    else if (i_step_req) free_next = CSFB_STEP;
    else if (i_pause_contact && req_q[CSFB_B_PEN]) free_next = CSFB_PAUSE;
    else free_next = CSFB_RUN;
  end

  always_comb begin
    case (state_q)
      CSFB_RUN:   state_d = free_next;
      CSFB_STOP:  state_d = free_next;
      CSFB_PAUSE: state_d = i_pause_contact ? CSFB_PAUSE : CSFB_RUN;
      CSFB_STEP:  state_d = free_next;
      default:    state_d = CSFB_STOP;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) state_q <= CSFB_STOP;
    else state_q <= state_d;
  end

  // step-start flags beyond the request word read as zero and never start a timer
  logic [STEP_N-1:0] step_req;
  for (g = 0; g < STEP_N; g++) begin : g_step
    if (CSFB_B_STEP0 + g < 16) begin : g_in
      assign step_req[g] = req_q[CSFB_B_STEP0+g];
    end else begin : g_out
      assign step_req[g] = 1'b0;
    end
  end

  // outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_error_reset_pulse <= 1'b0;
      o_batt_alarm_led    <= 1'b0;
      o_led_blank         <= 16'h0;
      o_step_timer_run    <= '0;
      o_net_read_inhibit  <= '0;
      o_net_write_inhibit <= '0;
      o_state             <= CSFB_STOP;
    end else begin
      o_error_reset_pulse <= erst_rise;
      o_batt_alarm_led    <= diag_d[CSFB_B_BATL];
      // blanking persists until the select word is changed and the command re-edged
      if (ledoff_rise) o_led_blank <= ledsel_q;
      o_step_timer_run    <= i_sfc_present ? step_req : '0;
      o_net_read_inhibit  <= rinh_q;
      o_net_write_inhibit <= winh_q;
      o_state             <= state_d;
    end
  end

  // read port, one cycle latency; unmapped reads as zero
  wire [15:0] state_word = {12'h0, standby_q[0], state_q == CSFB_STEP,
                            state_q == CSFB_PAUSE, state_q == CSFB_STOP};
  logic [15:0] rsel;
  always_comb begin
    if (i_bus.addr == CSFB_ADDR_DIAG) rsel = {1'b0, diag_q};
    else if (i_bus.addr == CSFB_ADDR_REQ) rsel = req_q;
    else if (i_bus.addr == CSFB_ADDR_STATE) rsel = state_word;
    else if (i_bus.addr == CSFB_ADDR_LEDSEL) rsel = ledsel_q;
    else if (i_bus.addr == CSFB_ADDR_HEADIO) rsel = headio_q;
    else if (i_bus.addr == CSFB_ADDR_NET) rsel = {4'h0, standby_q, winh_q, rinh_q};
    else if (i_bus.addr[3:2] == CSFB_ADDR_CLK0[3:2]) rsel = clk_words_q[i_bus.addr[1:0]];
    else rsel = 16'h0;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= 16'h0;
    end else if (i_bus.rd) begin
      o_rdata <= rsel;
    end else begin
      // data stand for one cycle only, so a stale word is never taken for a fresh read
      o_rdata <= 16'h0;
    end
  end

  // diag register writes are ignored: all its bits are system-set
  wire unused_ok = wr_diag;

endmodule : csfb_flag_bank

// ### csfb_flag_bank_monitor.sv
`timescale 1ns/1ps
module csfb_flag_bank_monitor
  import csfb_pkg::*;
#(
  parameter int STEP_N = 10,
  parameter int NET_N  = 4
) (
  input wire logic              i_sys_clk,
  input wire logic              i_srst,
  input wire csfb_bus_t         i_bus,
  input wire logic [15:0]       o_rdata,
  input wire logic              i_scan_end,
  input wire logic              i_sfc_present,
  input wire logic              i_batt_low_pin,
  input wire logic              i_stop_req,
  input wire logic              i_step_req,
  input wire logic              i_pause_contact,
  input wire logic              o_error_reset_pulse,
  input wire logic              o_batt_alarm_led,
  input wire logic [15:0]       o_led_blank,
  input wire logic              o_rtc_write,
  input wire logic [STEP_N-1:0] o_step_timer_run,
  input wire logic [NET_N-1:0]  o_net_write_inhibit,
  input wire csfb_state_t       o_state
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  property p_rdata_idle; !$past(i_bus.rd) |-> o_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_err_pulse; o_error_reset_pulse |=> !o_error_reset_pulse; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error reset pulse too long");
  property p_batt_set; i_batt_low_pin [*8] |-> o_batt_alarm_led; endproperty
  a_batt_set: assert property (p_batt_set) else $error("battery alarm missing");
  property p_batt_hold; o_batt_alarm_led |=> o_batt_alarm_led; endproperty
  a_batt_hold: assert property (p_batt_hold) else $error("battery alarm dropped");
  property p_stop; (i_stop_req && !i_step_req && !i_pause_contact) [*4] |-> o_state == CSFB_STOP; endproperty
  a_stop: assert property (p_stop) else $error("stop state missing");
  property p_led; !$stable(o_led_blank) |-> $past(i_bus.wr) || $past(i_bus.wr, 2) || $past(i_bus.wr, 3); endproperty
  a_led: assert property (p_led) else $error("led blanking changed without command");
  property p_rtc; o_rtc_write |-> ($past(i_scan_end) || i_scan_end) ##1 !o_rtc_write; endproperty
  a_rtc: assert property (p_rtc) else $error("clock write outside scan end");
  property p_step; |o_step_timer_run |-> i_sfc_present || $past(i_sfc_present); endproperty
  a_step: assert property (p_step) else $error("step timer runs without chart");
  property p_inh; !$stable(o_net_write_inhibit) |-> $past(i_bus.wr) || $past(i_bus.wr, 2); endproperty
  a_inh: assert property (p_inh) else $error("inhibit changed without write");
endmodule : csfb_flag_bank_monitor

// ### csfb_flag_bank_test.sv
`timescale 1ns/1ps
module csfb_flag_bank_test
  import csfb_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  csfb_bus_t   bus       = '0;
  csfb_err_t   err       = '0;
  logic        exec = 1'b0, scan = 1'b0, sfc = 1'b0, batt = 1'b0, sup_ok = 1'b1;
  logic        stop = 1'b1, step = 1'b0, pause = 1'b0;
  logic        dc = 1'b1, ioa = 1'b1;
  logic [15:0] rdata, blank;
  logic        erp, led, rtcw;
  logic [63:0] rtcd;
  logic [7:0]  stepr;
  logic [3:0]  rinh, winh;
  csfb_state_t state;
  int          err_count = 0, checked = 0, cyc = 0, nrst = 0, nrtc = 0;

  // short dip windows keep the run brief; expectations below assume 20/4
  csfb_flag_bank #(.STEP_N(8), .DIP_AC_CYC(20), .DIP_DC_CYC(4)) u_csfb_flag_bank (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(rdata), .i_err(err),
    .i_exec_strobe(exec), .i_scan_end(scan), .i_sfc_present(sfc), .i_batt_low_pin(batt),
    .i_supply_ok_pin(sup_ok), .i_supply_is_dc(dc), .i_stop_req(stop), .i_step_req(step),
    .i_pause_contact(pause), .i_io_change_allowed(ioa), .i_net_standby_cfg(4'h1),
    .i_rtc_time_bcd(64'h0001_5959_2312_2512), .o_error_reset_pulse(erp), .o_batt_alarm_led(led),
    .o_led_blank(blank), .o_rtc_write(rtcw), .o_rtc_wdata(rtcd), .o_step_timer_run(stepr),
    .o_net_read_inhibit(rinh), .o_net_write_inhibit(winh), .o_state(state));

  always #12.5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    cyc++;
    nrst += (erp === 1'b1);
    nrtc += (rtcw === 1'b1);
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // each access waits for its own edge so strobes never collide in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick

  // the request edge is detected a cycle late, so give it room first
  task automatic scan2;
    tick(2);
    repeat (2) begin
      @(posedge i_sys_clk) scan <= 1'b1;
      @(posedge i_sys_clk) scan <= 1'b0;
    end
    tick(3);
    #1;
  endtask : scan2

  task automatic pulse_err(input csfb_err_t e);
    @(posedge i_sys_clk);
    err <= e;
    exec <= 1'b1;
    @(posedge i_sys_clk);
    exec <= 1'b0;
    err <= '0;
  endtask : pulse_err

  task automatic t_reset;
    rd(CSFB_ADDR_DIAG, 16'h0000);
    rd(CSFB_ADDR_STATE, 16'h0009);
    chk("state", state, CSFB_STOP);
  endtask : t_reset

  task automatic t_errors;
    pulse_err('{ann_err: 1'b1, default: 1'b0});
    rd(CSFB_ADDR_DIAG, 16'h0401);
    pulse_err('{chk_err: 1'b1, default: 1'b0});
    rd(CSFB_ADDR_DIAG, 16'h0801);
    @(posedge i_sys_clk);
    err <= '{self_err: 1'b1, common_avail: 1'b1, indiv_avail: 1'b1, fuse_err: 1'b1, default: 1'b0};
    tick(2);
    rd(CSFB_ADDR_DIAG, 16'h090F);
    @(posedge i_sys_clk);
    err <= '0;
    rd(CSFB_ADDR_DIAG, 16'h0903);
  endtask : t_errors

  task automatic t_power;
    @(posedge i_sys_clk);
    batt <= 1'b1;
    tick(8);
    rd(CSFB_ADDR_DIAG, 16'h0933);
    batt <= 1'b0;
    tick(8);
    rd(CSFB_ADDR_DIAG, 16'h0913);
    chk("batt_led", led, 1'b1);
    sup_ok <= 1'b0;
    tick(2);
    sup_ok <= 1'b1;
    tick(8);
    rd(CSFB_ADDR_DIAG, 16'h0953);
  endtask : t_power

  task automatic t_err_reset;
    wr(CSFB_ADDR_REQ, 16'h0001);
    tick(4);
    rd(CSFB_ADDR_DIAG, 16'h0050);
    chk("reset_pulses", nrst, 1);
  endtask : t_err_reset

  task automatic t_state;
    @(posedge i_sys_clk);
    stop <= 1'b0;
    pause <= 1'b1;
    tick(5);
    #1;
    chk("state", state, CSFB_RUN);
    @(posedge i_sys_clk);
    pause <= 1'b0;
    wr(CSFB_ADDR_REQ, 16'h0004);
    pause <= 1'b1;
    tick(5);
    #1;
    chk("state", state, CSFB_PAUSE);
    rd(CSFB_ADDR_STATE, 16'h000A);
    @(posedge i_sys_clk);
    pause <= 1'b0;
    step <= 1'b1;
    tick(5);
    rd(CSFB_ADDR_STATE, 16'h000C);
    @(posedge i_sys_clk);
    step <= 1'b0;
  endtask : t_state

  task automatic t_led_net;
    wr(CSFB_ADDR_LEDSEL, 16'h00A5);
    wr(CSFB_ADDR_REQ, 16'h0002);
    tick(4);
    #1;
    chk("led_blank", blank, 16'h00A5);
    wr(CSFB_ADDR_NET, 16'h0035);
    tick(2);
    #1;
    chk("read_inhibit", rinh, 4'h5);
    chk("write_inhibit", winh, 4'h3);
    rd(CSFB_ADDR_NET, 16'h0135);
  endtask : t_led_net

  task automatic t_clock;
    logic [63:0] w = 64'h0003_3045_1510_2405;
    for (int g = 0; g < 4; g++)
      wr(CSFB_ADDR_CLK0 + 4'(g), w[16*g +: 16]);
    wr(CSFB_ADDR_REQ, 16'h0008);
    scan2();
    chk("rtc_wdata", rtcd, w);
    chk("rtc_writes", nrtc, 1);
    rd(CSFB_ADDR_DIAG, 16'h0050);
    wr(CSFB_ADDR_CLK0, 16'h24A5);
    wr(CSFB_ADDR_REQ, 16'h0000);
    wr(CSFB_ADDR_REQ, 16'h0008);
    scan2();
    chk("rtc_writes", nrtc, 1);
    rd(CSFB_ADDR_DIAG, 16'h2050);
    wr(CSFB_ADDR_REQ, 16'h0010);
    scan2();
    rd(CSFB_ADDR_CLK0 + 4'h1, 16'h2312);
  endtask : t_clock

  task automatic t_step_io;
    @(posedge i_sys_clk);
    sfc <= 1'b1;
    wr(CSFB_ADDR_REQ, 16'h0300);
    tick(3);
    #1;
    chk("step_run", stepr, 8'h03);
    @(posedge i_sys_clk);
    sfc <= 1'b0;
    tick(3);
    #1;
    chk("step_run", stepr, 8'h00);
    @(posedge i_sys_clk);
    ioa <= 1'b0;
    wr(CSFB_ADDR_REQ, 16'h0020);
    scan2();
    rd(CSFB_ADDR_DIAG, 16'h2050);
    @(posedge i_sys_clk);
    ioa <= 1'b1;
    scan2();
    rd(CSFB_ADDR_DIAG, 16'h6050);
  endtask : t_step_io

  initial begin
    tick(6);
    i_srst <= 1'b0;
    t_reset();
    t_errors();
    t_power();
    t_err_reset();
    t_state();
    t_led_net();
    t_clock();
    t_step_io();
    finish_test();
  end
endmodule : csfb_flag_bank_test

bind csfb_flag_bank csfb_flag_bank_monitor #(.STEP_N(STEP_N), .NET_N(NET_N)) u_csfb_flag_bank_monitor (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_bus(i_bus), .o_rdata(o_rdata), .i_scan_end(i_scan_end),
  .i_sfc_present(i_sfc_present), .i_batt_low_pin(i_batt_low_pin), .i_stop_req(i_stop_req),
  .i_step_req(i_step_req), .i_pause_contact(i_pause_contact), .o_error_reset_pulse(o_error_reset_pulse),
  .o_batt_alarm_led(o_batt_alarm_led), .o_led_blank(o_led_blank), .o_rtc_write(o_rtc_write),
  .o_step_timer_run(o_step_timer_run), .o_net_write_inhibit(o_net_write_inhibit), .o_state(o_state));
